// file: hdl/uie_pkg.sv
// Package for the USB IN endpoint response control block.
// Assumes one clock domain; shared by the design and the bench.
package uie_pkg;
  localparam int          NUM_EP       = 8;      // Endpoints with their own busy bit
  localparam int          DATA_W       = 8;      // Byte-wide packet data
  localparam int          FIFO_DEPTH   = 16;     // Words held per endpoint FIFO
  localparam int          MAX_PKT      = 8;      // Maximum packet size in bytes
  localparam int          EP_W         = 3;      // Endpoint number width
  localparam int          LEN_W        = 5;      // Packet length field width
  localparam logic [7:0]  BUSY_RST     = 8'h00;  // Busy bits after reset
  localparam logic [7:0]  END_FLAG_RST = 8'h00;  // End-of-transfer flags after reset

  // Answer given to an IN token
  typedef enum logic [1:0] {
    UIE_ANS_NONE,
    UIE_ANS_DATA,
    UIE_ANS_NAK
  } uie_ans_type;

  // IN token from the link side
  typedef struct packed {
    logic [EP_W-1:0] ep;
  } uie_token_type;

  // Answer summary: kind, endpoint and byte count (zero on a data answer means zero-length packet)
  typedef struct packed {
    uie_ans_type      kind;
    logic [EP_W-1:0]  ep;
    logic [LEN_W-1:0] len;
  } uie_resp_type;

  // One byte of packet data towards the link
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic              last;
  } uie_beat_type;
endpackage

// file: hdl/uie_in_ctrl.sv
// USB IN endpoint response control: per-endpoint FIFOs and the token answer logic.
// Assumes all inputs are synchronous to ref_clk; the link side serialises the answers.
`timescale 1ns/100ps

module uie_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic                         ref_clk,
  input  wire logic                         reset_n,
  input  wire logic [W-1:0]                 in_data,
  input  wire logic                         in_valid,
  output logic                              in_ready,
  output logic [W-1:0]                      out_data,
  output logic                              out_valid,
  input  wire logic                         out_ready,
  output logic [$clog2(DEPTH+1)-1:0]        count
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  // Elaboration check: pointer wrap relies on a power-of-two depth
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("uie_fifo: DEPTH must be a power of two, at least 2");
  end

  // Storage and pointers
  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_next;
  logic          push;
  logic          pop;

  // Handshakes on both sides and the next occupancy
  assign push       = in_valid && in_ready;
  assign pop        = out_valid && out_ready;
  assign count_next = count + CW'(push) - CW'(pop);
  assign out_data   = mem[rd_ptr_reg];

  // Storage has no reset; only words below count are ever read
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers wrap naturally since DEPTH is a power of two
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count      <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + AW'(push);
      rd_ptr_reg <= rd_ptr_reg + AW'(pop);
      count      <= count_next;
    end
  end

  // Flags come from flops so the source sees a clean ready
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      in_ready  <= count_next != CW'(DEPTH);
      out_valid <= count_next != '0;
    end
  end
endmodule

module uie_in_ctrl #(
  parameter int NUM_EP     = uie_pkg::NUM_EP,
  parameter int FIFO_DEPTH = uie_pkg::FIFO_DEPTH,
  parameter int MAX_PKT    = uie_pkg::MAX_PKT
) (
  input  wire logic                          ref_clk,
  input  wire logic                          reset_n,
  // Busy bit writes from the CPU side
  input  wire logic                          ctl_wr,
  input  wire logic [uie_pkg::EP_W-1:0]      ctl_ep,
  input  wire logic                          ctl_busy,
  output logic [NUM_EP-1:0]                  endpoint_control_reg,
  // End-of-transfer flags, cleared by a one per bit
  input  wire logic [NUM_EP-1:0]             end_flag_clr,
  output logic [NUM_EP-1:0]                  transfer_end_flag,
  // CPU data into the per-endpoint FIFOs
  input  wire logic                          cpu_valid,
  input  wire logic [uie_pkg::EP_W-1:0]      cpu_ep,
  input  wire logic [uie_pkg::DATA_W-1:0]    cpu_data,
  output logic [NUM_EP-1:0]                  cpu_ready,
  // IN tokens from the link
  input  wire logic                          tok_valid,
  input  wire uie_pkg::uie_token_type        tok,
  output logic                               tok_ready,
  // Answer summary and data bytes towards the link
  output logic                               resp_valid,
  output uie_pkg::uie_resp_type              resp,
  output logic                               tx_valid,
  output uie_pkg::uie_beat_type              tx,
  input  wire logic                          tx_ready
);
  localparam int CW = $clog2(FIFO_DEPTH+1);
  localparam int LW = uie_pkg::LEN_W;

  // Elaboration checks: NUM_EP must fill the endpoint field, MAX_PKT must fit both the FIFO and the length field
  if (NUM_EP != (1 << uie_pkg::EP_W)) begin : g_bad_num_ep
    $error("uie_in_ctrl: NUM_EP must match the endpoint field");
  end
  if (MAX_PKT < 1 || MAX_PKT > FIFO_DEPTH) begin : g_bad_max_pkt
    $error("uie_in_ctrl: MAX_PKT must lie in 1..FIFO_DEPTH");
  end
  if (MAX_PKT >= (1 << LW)) begin : g_bad_len_w
    $error("uie_in_ctrl: MAX_PKT too wide for the length field");
  end

  typedef enum logic [1:0] {
    UIE_IDLE,
    UIE_SEND,
    UIE_DRAIN
  } uie_state_type;

  // Sequencer state and the per-endpoint FIFO views
  uie_state_type                 state_reg;
  logic [uie_pkg::EP_W-1:0]      ep_reg;
  logic [LW-1:0]                 left_reg;
  logic [NUM_EP-1:0]             fifo_in_ready;
  logic [NUM_EP-1:0]             fifo_out_valid;
  logic [NUM_EP-1:0]             fifo_pop;
  logic [uie_pkg::DATA_W-1:0]    fifo_dout [NUM_EP];
  logic [CW-1:0]                 fifo_count [NUM_EP];
  logic [CW-1:0]                 tok_count;
  logic                          tok_busy;
  logic                          take_tok;
  logic                          beat_go;
  logic [LW-1:0]                 send_len;
  logic                          nak_now;
  logic                          drain_done;

  // One FIFO per endpoint so a stalled endpoint never blocks another
  for (genvar i = 0; i < NUM_EP; i++) begin : g_ep
    uie_fifo #(
      .W     (uie_pkg::DATA_W),
      .DEPTH (FIFO_DEPTH)
    ) u_fifo (
      .ref_clk   (ref_clk),
      .reset_n   (reset_n),
      .in_data   (cpu_data),
      .in_valid  (cpu_valid && cpu_ep == uie_pkg::EP_W'(i)),
      .in_ready  (fifo_in_ready[i]),
      .out_data  (fifo_dout[i]),
      .out_valid (fifo_out_valid[i]),
      .out_ready (fifo_pop[i]),
      .count     (fifo_count[i])
    );
    assign fifo_pop[i] = beat_go && ep_reg == uie_pkg::EP_W'(i);
  end

  // CPU ready comes straight from each FIFO's registered flag
  assign cpu_ready = fifo_in_ready;
  assign tok_count = fifo_count[tok.ep];
  assign tok_busy  = endpoint_control_reg[tok.ep];
  assign take_tok  = tok_valid && tok_ready;
  // A byte moves while bytes remain and the output slot is free
  assign beat_go   = state_reg == UIE_SEND && left_reg != '0 && (!tx_valid || tx_ready)
                     && fifo_out_valid[ep_reg];
  // Busy with less than a packet queued gets NAK
  assign nak_now    = tok_busy && tok_count < CW'(MAX_PKT);
  // Drain ends once the last byte has left the output register
  assign drain_done = state_reg == UIE_DRAIN && (!tx_valid || tx_ready);

  // Length sent for a token: capped at one packet, at most what is queued
  always_comb begin
    if (tok_count >= CW'(MAX_PKT)) begin
      send_len = LW'(MAX_PKT);
    end else begin
      send_len = LW'(tok_count);
    end
  end

  // Busy bits; the CPU side owns them and sets or clears one at a time
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      endpoint_control_reg <= NUM_EP'(uie_pkg::BUSY_RST);
    end else if (ctl_wr) begin
      endpoint_control_reg[ctl_ep] <= ctl_busy;
    end
  end

  // Token answer sequencer; busy is sampled only when a token is taken
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= UIE_IDLE;
    end else begin
      case (state_reg)
        UIE_IDLE: begin
          // A NAK or an empty packet has no bytes to wait for
          if (take_tok && (nak_now || send_len == '0)) begin
            state_reg <= UIE_DRAIN;
          end else if (take_tok) begin
            state_reg <= UIE_SEND;
          end
        end
        UIE_SEND: begin
          if (beat_go && left_reg == LW'(1)) begin
            state_reg <= UIE_DRAIN;
          end
        end
        UIE_DRAIN: begin
          // Wait for the last byte to leave before taking the next token
          if (drain_done) begin
            state_reg <= UIE_IDLE;
          end
        end
        default: begin
          state_reg <= UIE_IDLE;
        end
      endcase
    end
  end

  // Token ready drops for the whole answer and returns when the drain ends
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tok_ready <= 1'b0;
    end else if (take_tok) begin
      tok_ready <= 1'b0;
    end else if (state_reg == UIE_IDLE || drain_done) begin
      tok_ready <= 1'b1;
    end
  end

  // Answer summary: valid for one cycle, contents held until the next answer
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      resp_valid <= 1'b0;
      resp       <= '{kind: uie_pkg::UIE_ANS_NONE, ep: '0, len: '0};
    end else begin
      resp_valid <= take_tok;
      if (take_tok && nak_now) begin
        resp <= '{kind: uie_pkg::UIE_ANS_NAK, ep: tok.ep, len: '0};
      end else if (take_tok) begin
        // Busy clear may give a short or empty packet; busy set only a full one
        resp <= '{kind: uie_pkg::UIE_ANS_DATA, ep: tok.ep, len: send_len};
      end
    end
  end

  // Endpoint and bytes left of the packet in flight; a NAK leaves nothing to send
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ep_reg   <= '0;
      left_reg <= '0;
    end else if (take_tok) begin
      ep_reg   <= tok.ep;
      left_reg <= nak_now ? '0 : send_len;
    end else if (beat_go) begin
      left_reg <= left_reg - LW'(1);
    end
  end

  // Output byte register; last marks the final byte of the packet
  // Holding the byte while stalled spares the link side a skid buffer
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_valid <= 1'b0;
      tx       <= '0;
    end else if (beat_go) begin
      tx_valid <= 1'b1;
      tx       <= '{data: fifo_dout[ep_reg], last: left_reg == LW'(1)};
    end else if (tx_ready) begin
      tx_valid <= 1'b0;
    end
  end

  // End flag: a short or empty data packet with busy clear closes the transfer;
  // the set wins over a clear arriving in the same cycle;
  // a full packet never ends a transfer, since the host expects more
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      transfer_end_flag <= NUM_EP'(uie_pkg::END_FLAG_RST);
    end else begin
      for (int i = 0; i < NUM_EP; i++) begin
        if (take_tok && tok.ep == uie_pkg::EP_W'(i) && !tok_busy && send_len < LW'(MAX_PKT)) begin
          transfer_end_flag[i] <= 1'b1;
        end else if (end_flag_clr[i]) begin
          transfer_end_flag[i] <= 1'b0;
        end
      end
    end
  end
endmodule

// file: tb/uie_in_ctrl_props.sv
// Checker of the IN token answer rules.
// Assumes one clock, ref_clk, and reset_n active low.
`timescale 1ns/100ps
module uie_in_ctrl_props #(
  parameter int NUM_EP  = 8,
  parameter int MAX_PKT = 8
) (
  input wire logic                   ref_clk,
  input wire logic                   reset_n,
  input wire logic                   ctl_wr,
  input wire logic [NUM_EP-1:0]      endpoint_control_reg,
  input wire logic [NUM_EP-1:0]      transfer_end_flag,
  input wire logic                   tok_valid,
  input wire uie_pkg::uie_token_type tok,
  input wire logic                   tok_ready,
  input wire logic                   resp_valid,
  input wire uie_pkg::uie_resp_type  resp,
  input wire logic                   tx_valid,
  input wire uie_pkg::uie_beat_type  tx,
  input wire logic                   tx_ready
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Token taken and the busy bit of its endpoint at that edge
  wire take = tok_valid && tok_ready;
  wire bsy  = endpoint_control_reg[tok.ep];

  reset_clear_a: assert property (disable iff (1'b0) !reset_n |=> endpoint_control_reg == '0)
    else $error("busy bits not cleared in reset");
  busy_still_a: assert property (!ctl_wr |=> $stable(endpoint_control_reg))
    else $error("busy bits moved without a write");
  busy_answer_a: assert property (take && bsy |=> resp_valid && resp.ep == $past(tok.ep) &&
    (resp.kind == uie_pkg::UIE_ANS_NAK || resp.len == MAX_PKT)) else $error("busy answer wrong");
  done_answer_a: assert property (take && !bsy |=> resp_valid && resp.kind == uie_pkg::UIE_ANS_DATA &&
    resp.len <= MAX_PKT) else $error("done answer wrong");
  end_flag_a: assert property ((take && !bsy) ##1 (resp.len < MAX_PKT) |-> transfer_end_flag[resp.ep])
    else $error("end flag not set after short packet");
  no_token_mid_a: assert property (tx_valid |-> !tok_ready)
    else $error("token taken during a packet");
  tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx))
    else $error("byte dropped while stalled");
  cover property (resp_valid && resp.kind == uie_pkg::UIE_ANS_NAK);
  cover property (resp_valid && resp.kind == uie_pkg::UIE_ANS_DATA && resp.len == 0);
  cover property (tx_valid && !tx_ready);
endmodule

bind uie_in_ctrl uie_in_ctrl_props #(.NUM_EP(NUM_EP), .MAX_PKT(MAX_PKT)) u_props (.ref_clk, .reset_n, .ctl_wr,
  .endpoint_control_reg, .transfer_end_flag, .tok_valid, .tok, .tok_ready, .resp_valid, .resp, .tx_valid, .tx,
  .tx_ready);

// file: tb/uie_host_model.sv
// Host model: issues IN tokens and collects the answer and bytes.
// Assumes the bench calls in_token and reads ans and q.
`timescale 1ns/100ps
module uie_host_model (
  input wire logic                   ref_clk,
  input wire logic                   tok_ready,
  input wire logic                   resp_valid,
  input wire uie_pkg::uie_resp_type  resp,
  input wire logic                   tx_valid,
  input wire uie_pkg::uie_beat_type  tx,
  output uie_pkg::uie_token_type     tok,
  output logic                       tok_valid = 1'b0,
  output logic                       tx_ready = 1'b1
);
  uie_pkg::uie_resp_type ans;
  logic [8:0]            q[$];
  logic                  slow = 1'b0;
  // A slow host stalls every other cycle
  always @(negedge ref_clk) tx_ready <= slow ? ~tx_ready : 1'b1;
  // Record the answer summary and each accepted byte
  always @(posedge ref_clk) begin
    if (resp_valid) ans <= resp;
    if (tx_valid && tx_ready) q.push_back(tx);
  end
  // Token held until taken; released lines show the inverse, not the last value
  task automatic in_token(input logic [2:0] ep);
    q = {};
    ans = '0;
    @(negedge ref_clk);
    tok_valid = 1'b1;
    tok.ep = ep;
    do @(posedge ref_clk); while (!tok_ready);
    @(negedge ref_clk);
    tok_valid = 1'b0;
    tok.ep = ~ep;
    do @(negedge ref_clk); while (!tok_ready);
  endtask
endmodule

// file: tb/uie_in_ctrl_bench.sv
// Bench for the IN endpoint answer block with a host model.
// Assumes eight endpoints, 16-byte FIFOs and 8-byte packets.
`timescale 1ns/100ps
module uie_in_ctrl_bench;
  logic                   ref_clk = 1'b0, reset_n = 1'b0, ctl_wr = 1'b0, ctl_busy = 1'b0, cpu_valid = 1'b0;
  logic [2:0]             ctl_ep = '0, cpu_ep = '0;
  logic [7:0]             cpu_data = '0, end_flag_clr = '0, endpoint_control_reg, transfer_end_flag, cpu_ready;
  logic                   tok_valid, tok_ready, resp_valid, tx_valid, tx_ready;
  uie_pkg::uie_token_type tok;
  uie_pkg::uie_resp_type  resp;
  uie_pkg::uie_beat_type  tx;
  logic [7:0]             exq[8][$];
  int                     seq[8], error_cnt = 0, check_count = 0, cyc = 0;

  uie_in_ctrl DUT (.ref_clk, .reset_n, .ctl_wr, .ctl_ep, .ctl_busy, .endpoint_control_reg, .end_flag_clr,
    .transfer_end_flag, .cpu_valid, .cpu_ep, .cpu_data, .cpu_ready, .tok_valid, .tok, .tok_ready, .resp_valid,
    .resp, .tx_valid, .tx, .tx_ready);
  uie_host_model host (.ref_clk, .tok_ready, .resp_valid, .resp, .tx_valid, .tx, .tok, .tok_valid, .tx_ready);

  // Clock at 10 MHz
  always #50 ref_clk = ~ref_clk;
  // Cut a hang short; the run needs under two hundred cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      tally_and_finish;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic set_busy(input logic [2:0] ep, input logic b);
    @(negedge ref_clk);
    ctl_wr = 1'b1;
    ctl_ep = ep;
    ctl_busy = b;
    @(negedge ref_clk);
    ctl_wr = 1'b0;
    chk(endpoint_control_reg[ep], b);
  endtask
  // Bytes held until the FIFO takes them; a full FIFO simply stalls here
  task automatic push(input logic [2:0] ep, input int n);
    repeat (n) begin
      @(negedge ref_clk);
      cpu_valid = 1'b1;
      cpu_ep = ep;
      cpu_data = {ep, 5'(seq[ep])};
      do @(posedge ref_clk); while (!cpu_ready[ep]);
      exq[ep].push_back(cpu_data);
      seq[ep]++;
    end
    @(negedge ref_clk);
    cpu_valid = 1'b0;
    cpu_data = ~cpu_data;
  endtask
  task automatic ask(input logic [2:0] ep, input uie_pkg::uie_ans_type k, input int len);
    logic [7:0] e;
    host.in_token(ep);
    chk(host.ans.kind, k);
    chk(host.ans.ep, ep);
    if (k != uie_pkg::UIE_ANS_NAK) chk(host.ans.len, len);
    chk(host.q.size(), len);
    foreach (host.q[i]) begin
      e = exq[ep].pop_front();
      chk(host.q[i], {e, 1'(i == len - 1)});
    end
  endtask
  // Empty endpoint, busy clear: zero-length packet, flag, then clear it
  task automatic t_zlp;
    chk({endpoint_control_reg, transfer_end_flag}, 16'h0000);
    ask(3'h0, uie_pkg::UIE_ANS_DATA, 0);
    chk(transfer_end_flag, 8'h01);
    @(negedge ref_clk);
    end_flag_clr = 8'h01;
    @(negedge ref_clk);
    end_flag_clr = 8'h00;
    chk(transfer_end_flag, 8'h00);
  endtask
  // Busy endpoint: NAK at seven bytes, full packet, then the short tail
  task automatic t_busy;
    set_busy(3'h1, 1'b1);
    chk(endpoint_control_reg, 8'h02);
    push(3'h1, 7);
    ask(3'h1, uie_pkg::UIE_ANS_NAK, 0);
    push(3'h1, 4);
    host.slow = 1'b1;
    ask(3'h1, uie_pkg::UIE_ANS_DATA, 8);
    host.slow = 1'b0;
    chk(transfer_end_flag, 8'h00);
    set_busy(3'h1, 1'b0);
    ask(3'h1, uie_pkg::UIE_ANS_DATA, 3);
    chk(transfer_end_flag, 8'h02);
    set_busy(3'h1, 1'b1);
    ask(3'h1, uie_pkg::UIE_ANS_NAK, 0);
  endtask
  // Full FIFO refuses; busy set in mid-packet only affects later tokens
  task automatic t_fill;
    push(3'h2, 16);
    @(negedge ref_clk);
    chk(cpu_ready, 8'hFB);
    host.slow = 1'b1;
    fork
      ask(3'h2, uie_pkg::UIE_ANS_DATA, 8);
      begin
        repeat (4) @(negedge ref_clk);
        set_busy(3'h2, 1'b1);
      end
    join
    ask(3'h2, uie_pkg::UIE_ANS_DATA, 8);
    host.slow = 1'b0;
    ask(3'h2, uie_pkg::UIE_ANS_NAK, 0);
  endtask
  // Mid-run reset: busy bits, end flags and queued bytes all go, then an empty answer
  task automatic t_reset;
    set_busy(3'h4, 1'b1);
    push(3'h4, 2);
    @(negedge ref_clk);
    reset_n = 1'b0;
    @(negedge ref_clk);
    chk({endpoint_control_reg, transfer_end_flag, cpu_ready}, 24'h000000);
    reset_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    exq[4].delete();
    ask(3'h4, uie_pkg::UIE_ANS_DATA, 0);
    chk(transfer_end_flag, 8'h10);
  endtask
  // Main sequence after five cycles of reset
  initial begin
    repeat (5) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    t_zlp;
    t_busy;
    t_fill;
    t_reset;
    tally_and_finish;
  end
endmodule
